// *** logic/ibl_pkg.sv ***
// Constants shared by the instrument bus listener
package ibl_pkg;
  // Command byte groups, 7-bit codes with bit 7 ignored
  localparam logic [6:0] LISTEN_BASE = 7'h20;
  localparam logic [6:0] TALK_BASE = 7'h40;
  localparam logic [6:0] UNLISTEN_CODE = 7'h3F;
  localparam logic [6:0] UNTALK_CODE = 7'h5F;
  // Universal command: device clear
  localparam logic [6:0] DEV_CLEAR_CODE = 7'h14;
  // Addressed commands: selected device clear, group execute trigger
  localparam logic [6:0] SEL_CLEAR_CODE = 7'h04;
  localparam logic [6:0] TRIGGER_CODE = 7'h08;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [3:0] {
    IBL_IDLE = 4'h1,
    IBL_READY = 4'h2,
    IBL_TAKE = 4'h4,
    IBL_DONE = 4'h8
  } ibl_hs_t;
endpackage

// *** logic/ibl_sync.sv ***
// Two-stage synchroniser for asynchronous bus control lines
`timescale 1ns/1ns
module ibl_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Lines
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = clk_en ? async_in : meta_r;
    sync_nxt = clk_en ? meta_r : sync_r;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule

// *** logic/ibl_cmd.sv ***
// Command decoder: listen/talk addressing, unlisten and bus commands
`timescale 1ns/1ns
module ibl_cmd (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Configuration
  input wire logic [6:0] own_addr,
  // Byte strobe and state
  input wire logic cmd_stb,
  input wire logic [7:0] cmd_byte,
  input wire logic ifc_act,
  input wire logic ren_act,
  // Results
  output logic listen_addr,
  output logic talk_addr,
  output logic clear_pulse,
  output logic trigger_pulse
);
  logic lsn_r, lsn_nxt, tlk_r, tlk_nxt, clr_r, clr_nxt, trg_r, trg_nxt;
  logic [6:0] c;

  // Talk or listen code for this device; upper address values have no code
  function automatic logic addr_hit(input logic [6:0] code, input logic [6:0] base,
      input logic [6:0] addr);
    addr_hit = (code == (base | {2'b00, addr[4:0]})) && (addr[6:5] == 2'b00);
  endfunction

  always_comb begin
    c = cmd_byte[6:0];
    lsn_nxt = lsn_r;
    tlk_nxt = tlk_r;
    clr_nxt = 1'b0;
    trg_nxt = 1'b0;
    if (ifc_act) begin
      lsn_nxt = 1'b0;
      tlk_nxt = 1'b0;
    end else if (cmd_stb && ren_act) begin
      if (c == ibl_pkg::UNLISTEN_CODE) begin
        lsn_nxt = 1'b0;
      end else if (c == ibl_pkg::UNTALK_CODE) begin
        tlk_nxt = 1'b0;
      end else if (addr_hit(c, ibl_pkg::LISTEN_BASE, own_addr)) begin
        lsn_nxt = 1'b1;
      end else if (addr_hit(c, ibl_pkg::TALK_BASE, own_addr)) begin
        tlk_nxt = 1'b1;
        lsn_nxt = 1'b0;
      end else if (c[6:5] == 2'b10) begin
        tlk_nxt = 1'b0;
      end else if (c == ibl_pkg::DEV_CLEAR_CODE) begin
        clr_nxt = 1'b1;
      end else if (c == ibl_pkg::SEL_CLEAR_CODE) begin
        clr_nxt = lsn_r;
      end else if (c == ibl_pkg::TRIGGER_CODE) begin
        trg_nxt = lsn_r;
      end
      // Any other code leaves state untouched
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lsn_r <= 1'b0;
      tlk_r <= 1'b0;
      clr_r <= 1'b0;
      trg_r <= 1'b0;
    end else if (clk_en) begin
      lsn_r <= lsn_nxt;
      tlk_r <= tlk_nxt;
      clr_r <= clr_nxt;
      trg_r <= trg_nxt;
    end
  end

  assign listen_addr = lsn_r;
  assign talk_addr = tlk_r;
  assign clear_pulse = clr_r;
  assign trigger_pulse = trg_r;
endmodule

// *** logic/ibl_listener.sv ***
// Listener-side logic for a byte-parallel instrument bus
`timescale 1ns/1ns
module ibl_listener (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Configuration
  input wire logic [6:0] own_addr,
  // Bus lines, true = asserted (electrically low)
  input wire logic [7:0] dio_in,
  input wire logic dav_in,
  input wire logic atn_in,
  input wire logic ifc_in,
  input wire logic ren_in,
  // Open-drain handshake lines: oe high pulls the line low (true)
  output logic nrfd_out,
  output logic nrfd_oe,
  output logic ndac_out,
  output logic ndac_oe,
  // User side: received data
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // User side: status
  output logic listen_addr,
  output logic talk_addr,
  output logic remote_mode,
  output logic clear_pulse,
  output logic trigger_pulse
);
  logic [3:0] ctl_sync;
  logic dav_s, atn_s, ifc_s, ren_s;
  ibl_pkg::ibl_hs_t st_r, st_nxt;
  logic [7:0] data_r, data_nxt;
  logic rxv_r, rxv_nxt;
  logic [7:0] rxd_r, rxd_nxt;
  logic cmd_stb;

  ibl_sync #(.W(4)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in({dav_in, atn_in, ifc_in, ren_in}),
    .sync_out(ctl_sync)
  );
  assign {dav_s, atn_s, ifc_s, ren_s} = ctl_sync;

  // A command byte is taken in the capture state while attention is true
  assign cmd_stb = (st_r == ibl_pkg::IBL_TAKE) && atn_s;

  ibl_cmd u_cmd (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .own_addr(own_addr),
    .cmd_stb(cmd_stb),
    .cmd_byte(data_r),
    .ifc_act(ifc_s),
    .ren_act(ren_s),
    .listen_addr(listen_addr),
    .talk_addr(talk_addr),
    .clear_pulse(clear_pulse),
    .trigger_pulse(trigger_pulse)
  );

  always_comb begin
    st_nxt = st_r;
    data_nxt = data_r;
    rxv_nxt = rxv_r && !rx_ready;
    rxd_nxt = rxd_r;
    case (st_r)
      ibl_pkg::IBL_IDLE: begin
        // Ready once the previous byte is drained, or for commands
        if (!dav_s && (atn_s || (listen_addr && !rxv_r))) begin
          st_nxt = ibl_pkg::IBL_READY;
        end
      end
      ibl_pkg::IBL_READY: begin
        if (ifc_s) begin
          st_nxt = ibl_pkg::IBL_IDLE;
        end else if (dav_s) begin
          // Data lines sampled only after valid has been synchronised
          data_nxt = dio_in;
          st_nxt = ibl_pkg::IBL_TAKE;
        end else if (!atn_s && (!listen_addr || rxv_r)) begin
          // Data mode with no address or an undrained byte: not-ready again
          st_nxt = ibl_pkg::IBL_IDLE;
        end
      end
      ibl_pkg::IBL_TAKE: begin
        if (!atn_s && listen_addr && ren_s) begin
          rxv_nxt = 1'b1;
          // User byte kept apart so later command bytes cannot overwrite it
          rxd_nxt = data_r;
        end
        st_nxt = ibl_pkg::IBL_DONE;
      end
      ibl_pkg::IBL_DONE: begin
        if (!dav_s) begin
          st_nxt = ibl_pkg::IBL_IDLE;
        end
      end
      default: st_nxt = ibl_pkg::IBL_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ibl_pkg::IBL_IDLE;
      data_r <= 8'h00;
      rxv_r <= 1'b0;
      rxd_r <= 8'h00;
    end else if (clk_en) begin
      st_r <= st_nxt;
      data_r <= data_nxt;
      rxv_r <= rxv_nxt;
      rxd_r <= rxd_nxt;
    end
  end

  // Not-ready released only in the ready state
  assign nrfd_out = 1'b0;
  assign nrfd_oe = (st_r != ibl_pkg::IBL_READY);
  // Not-accepted released only once the byte is captured
  assign ndac_out = 1'b0;
  assign ndac_oe = (st_r != ibl_pkg::IBL_DONE);
  assign rx_data = rxd_r;
  assign rx_valid = rxv_r;
  assign remote_mode = ren_s;
endmodule

// *** verification/ibl_listener_sva.sv ***
// Port checker for the bus listener
`timescale 1ns/1ns
module ibl_listener_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic dav_in,
  input wire logic ifc_in,
  input wire logic ren_in,
  input wire logic nrfd_oe,
  input wire logic ndac_oe,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic listen_addr,
  input wire logic remote_mode,
  input wire logic trigger_pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_accept_late: assert property ($fell(ndac_oe) |-> nrfd_oe && dav_in && $past(dav_in, 2))
    else $error("early accept");
  a_ready_idle: assert property (!nrfd_oe |-> ndac_oe) else $error("ready while open");
  a_valid_accept: assert property ($rose(rx_valid) |-> $fell(ndac_oe))
    else $error("byte without accept");
  a_valid_hold: assert property (rx_valid && !rx_ready |=> rx_valid) else $error("byte lost");
  a_ifc_unaddr: assert property (ifc_in [*5] |-> !listen_addr) else $error("clear ignored");
  a_remote_on: assert property (ren_in [*5] |-> remote_mode) else $error("remote late");
  a_remote_off: assert property (!ren_in [*5] |-> !remote_mode) else $error("remote stuck");
  a_trig_listen: assert property (trigger_pulse |-> listen_addr && remote_mode)
    else $error("trigger unaddressed");
  c_byte: cover property ($rose(rx_valid));
  c_trig: cover property (trigger_pulse);
  c_ifc: cover property (ifc_in [*5]);
endmodule
bind ibl_listener ibl_listener_sva u_sva (.sys_clk, .rst_n, .dav_in, .ifc_in, .ren_in, .nrfd_oe,
  .ndac_oe, .rx_valid, .rx_ready, .listen_addr, .remote_mode, .trigger_pulse);

// *** verification/ibl_talker.sv ***
// Talker model driving bytes through the three-wire handshake
`timescale 1ns/1ns
module ibl_talker (
  // Request
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [7:0] tx_byte,
  // Bus
  input wire logic nrfd_oe,
  input wire logic ndac_oe,
  output logic [7:0] dio,
  output logic dav,
  output logic busy
);
  initial begin
    dav = 1'h0;
    dio = 8'h5A;
    busy = 1'h0;
    forever begin
      @(posedge sys_clk);
      if (go) begin
        busy <= 1'h1;
        while (nrfd_oe) @(posedge sys_clk);
        dio <= tx_byte;
        repeat (1 + tx_byte[1:0]) @(posedge sys_clk);
        dav <= 1'h1;
        while (ndac_oe) @(posedge sys_clk);
        dav <= 1'h0;
        dio <= ~tx_byte;
        busy <= 1'h0;
      end
    end
  end
endmodule

// *** verification/ibl_listener_test.sv ***
// Random bench for the bus listener against a reference model
`timescale 1ns/1ns
module ibl_listener_test;
  logic sys_clk = 1'h0, rst_n = 1'h0, go = 1'h0, atn_in = 1'h0, ifc_in = 1'h0, ren_in = 1'h0;
  logic rx_ready = 1'h0, exp_l = 1'h0, exp_t = 1'h0, a, busy, dav_in, nrfd_oe, ndac_oe;
  logic rx_valid, listen_addr, talk_addr, remote_mode, clear_pulse, trigger_pulse;
  logic [7:0] tx_byte = 8'h00, b, dio_in, rx_data, q [$];
  logic [6:0] codes [10] = '{7'h25, 7'h3F, 7'h45, 7'h4A, 7'h5F, 7'h14, 7'h04, 7'h08, 7'h01, 7'h2A};
  int n_fail, cmp_count, n_clr, n_trg, e_clr, e_trg, r, k, i;
  integer seed = 32'h4FEE495B;
  ibl_listener dut (.sys_clk, .rst_n, .clk_en(1'h1), .own_addr(7'h05), .dio_in, .dav_in, .atn_in,
    .ifc_in, .ren_in, .nrfd_out(), .nrfd_oe, .ndac_out(), .ndac_oe, .rx_data, .rx_valid,
    .rx_ready, .listen_addr, .talk_addr, .remote_mode, .clear_pulse, .trigger_pulse);
  ibl_talker peer (.sys_clk, .go, .tx_byte, .nrfd_oe, .ndac_oe, .dio(dio_in), .dav(dav_in), .busy);
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    rx_ready <= 1'($random(seed));
    n_clr += (clear_pulse === 1'h1);
    n_trg += (trigger_pulse === 1'h1);
    if ({rx_valid, rx_ready} === 2'h3) chk(rx_data, q.size() ? q.pop_front() : 8'hXX);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    chk({4'h0, nrfd_oe, ndac_oe, rx_valid, listen_addr}, 8'h0C);
    rst_n <= 1'h1;
    ren_in <= 1'h1;
    repeat (4) @(posedge sys_clk);
    for (int j = 0; j < 150; j++) begin
      r = $random(seed);
      k = r[31:16] % 10;
      if (r[4:2] == 3'h0) begin
        ifc_in <= 1'h1;
        repeat (6) @(posedge sys_clk);
        ifc_in <= 1'h0;
        {exp_l, exp_t} = 2'h0;
      end else if (r[4:2] == 3'h1) begin
        ren_in <= r[5];
      end else begin
        a = !(r[3] && exp_l && ren_in);
        b = a ? {r[6], codes[k]} : r[15:8];
        if (!a) q.push_back(b);
        else if (ren_in) case (k)
          0: exp_l = 1'h1;
          1: exp_l = 1'h0;
          2: {exp_t, exp_l} = 2'h2;
          3, 4: exp_t = 1'h0;
          5: e_clr++;
          6: e_clr += exp_l;
          7: e_trg += exp_l;
          default: ;
        endcase
        atn_in <= a;
        // Let attention settle in the listener before the talker looks at not-ready
        repeat (3) @(posedge sys_clk);
        tx_byte <= b;
        go <= 1'h1;
        @(posedge sys_clk);
        go <= 1'h0;
        @(posedge sys_clk);
        for (i = 0; i < 400 && busy !== 1'h0; i++) @(posedge sys_clk);
        if (busy !== 1'h0) begin
          n_fail++;
          tally_and_finish;
        end
      end
      repeat (6) @(posedge sys_clk);
      chk({5'h0, remote_mode, talk_addr, listen_addr}, {5'h0, ren_in, exp_t, exp_l});
    end
    repeat (20) @(posedge sys_clk);
    chk(8'(q.size()), 8'h00);
    chk(8'(n_clr), 8'(e_clr));
    chk(8'(n_trg), 8'(e_trg));
    tally_and_finish;
  end
endmodule
